// ==== hdl/eeac_top.sv ====
// eeac_top: axi4-lite register front end and programming sequencer of the eeprom
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - 12-bit byte address split over low and high registers, linear over 4 KB
// - address bits 15:12 and control bits 7:6 read as zero, not writable
// - address has no reset value; software loads it before any access
// - erase+write stores the data register byte at the addressed location; erase stores FF, write ANDs the byte in
// - a read strobe loads the addressed byte into the data register
// - mode 00 erase+write 3.4ms, 01 erase 1.8ms, 10 write 1.8ms, 11 reserved
// - mode field writes ignored while busy is set
// - reset clears mode to 00 unless programming is in progress
// - bit 3 enables ready interrupt, gated by cpu global interrupt enable
// - ready request is a level, high whenever busy is clear while bit 3 and cpu global interrupt enable are both set
// - busy set starts write only within four cycles after arming
// - hardware clears arm bit four cycles after software set it
// - busy write without arm does nothing
// - no programming starts while flash self-programming is active
// - hardware clears busy when the programming time elapses
// - starting a write stalls the cpu two cycles
// - read strobe reads immediately and stalls the cpu four cycles, two when the same write also starts programming
// - during programming no read and no address change
module eeac_top #(
    parameter int CYC_ATOMIC_P = eeac_pkg::CYC_ATOMIC,
    parameter int CYC_SINGLE_P = eeac_pkg::CYC_SINGLE
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // cpu side
    input  wire logic        cpu_global_irq_en,
    input  wire logic        self_prog_active,
    output logic             cpu_stall,
    output logic             ready_irq
);
    import eeac_pkg::*;

    // ---------------------------------------------------------------
    // storage and registers
    // ---------------------------------------------------------------
    logic [7:0]        mem_q [DEPTH];
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]        data_q;
    logic [1:0]        mode_q;
    logic              irqen_q;
    logic              arm_q;
    logic [2:0]        arm_cnt_q;
    logic              busy_q;
    logic [TMR_W-1:0]  tmr_q;
    logic [2:0]        stall_q;
    eeac_state_type    state_q;

    // ---------------------------------------------------------------
    // axi write channel
    // ---------------------------------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  aw_idx_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        wr_lane0;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_lane0      = wr_fire && w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_idx_q  <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_idx_q >= IDX_ADDR_LOW && aw_idx_q <= IDX_STATUS)
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_addr_lo;
    logic wr_addr_hi;
    logic wr_data;
    logic wr_ctl;
    logic start_prog;
    logic start_read;
    assign wr_addr_lo = wr_lane0 && aw_idx_q == IDX_ADDR_LOW;
    assign wr_addr_hi = wr_lane0 && aw_idx_q == IDX_ADDR_HIGH;
    assign wr_data    = wr_lane0 && aw_idx_q == IDX_DATA;
    assign wr_ctl     = wr_lane0 && aw_idx_q == IDX_CONTROL;
    // arming window still open and flash not busy
    // mode written with the start decides the cycle, so timer and cell action agree
    logic [1:0] mode_next;
    assign mode_next  = w_data_q[CTL_MODE_H:CTL_MODE_L];
    assign start_prog = wr_ctl && w_data_q[CTL_BUSY] && arm_q && !busy_q
                        && !self_prog_active && mode_next != MODE_RSVD;
    assign start_read = wr_ctl && w_data_q[CTL_READ] && !busy_q;

    // ---------------------------------------------------------------
    // address, data, control
    // ---------------------------------------------------------------
    // address deliberately not reset: content is undefined until loaded
    always_ff @(posedge aclk) begin
        if (!busy_q) begin
            if (wr_addr_lo) begin
                addr_q[7:0] <= w_data_q[7:0];
            end
            if (wr_addr_hi) begin
                addr_q[ADDR_W-1:8] <= w_data_q[ADDR_W-9:0] & ADDR_HI_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= 8'h00;
        end else if (start_read) begin
            data_q <= mem_q[addr_q];
        end else if (wr_data) begin
            data_q <= w_data_q[7:0];
        end
    end

    // mode survives reset while a programming cycle runs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if (!busy_q) begin
                mode_q <= MODE_RESET;
            end
        end else if (wr_ctl && !busy_q) begin
            mode_q <= w_data_q[CTL_MODE_H:CTL_MODE_L];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irqen_q <= 1'b0;
        end else if (wr_ctl) begin
            irqen_q <= w_data_q[CTL_IRQEN];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'h0;
        end else if (wr_ctl && w_data_q[CTL_ARM] && !w_data_q[CTL_BUSY]) begin
            arm_q     <= 1'b1;
            arm_cnt_q <= 3'(ARM_CYCLES);
        end else if (start_prog) begin
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'h0;
        end else if (arm_q) begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
            if (arm_cnt_q == 3'h1) begin
                arm_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // programming sequencer
    // ---------------------------------------------------------------
    // busy and timer are not reset either, so a running cycle completes
    always_ff @(posedge aclk) begin
        unique case (state_q)
            EEAC_IDLE: begin
                if (start_prog) begin
                    busy_q  <= 1'b1;
                    state_q <= EEAC_PROG;
                    tmr_q   <= (mode_next == MODE_ERASE_WRITE)
                               ? TMR_W'(CYC_ATOMIC_P - 1) : TMR_W'(CYC_SINGLE_P - 1);
                end else begin
                    busy_q <= 1'b0;
                end
            end
            EEAC_PROG: begin
                if (tmr_q == '0) begin
                    busy_q  <= 1'b0;
                    state_q <= EEAC_IDLE;
                end else begin
                    tmr_q <= tmr_q - TMR_W'(1);
                end
            end
            default: begin
                busy_q  <= 1'b0;
                state_q <= EEAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (state_q == EEAC_PROG && tmr_q == '0) begin
            unique case (mode_q)
                MODE_ERASE_WRITE: mem_q[addr_q] <= data_q;
                MODE_ERASE:       mem_q[addr_q] <= ERASED_BYTE;
                MODE_WRITE:       mem_q[addr_q] <= mem_q[addr_q] & data_q;
                default:          mem_q[addr_q] <= mem_q[addr_q];
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_q <= 3'h0;
        end else if (start_prog) begin
            stall_q <= 3'(WSTALL_CYC);
        end else if (start_read) begin
            stall_q <= 3'(RSTALL_CYC);
        end else if (stall_q != 3'h0) begin
            stall_q <= stall_q - 3'h1;
        end
    end

    assign cpu_stall = stall_q != 3'h0;
    assign ready_irq = irqen_q && cpu_global_irq_en && !busy_q;

    // ---------------------------------------------------------------
    // axi read channel
    // ---------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            unique case (s_axi_araddr[9:2])
                IDX_ADDR_LOW:  s_axi_rdata[7:0] <= addr_q[7:0];
                IDX_ADDR_HIGH: s_axi_rdata[3:0] <= addr_q[ADDR_W-1:8];
                IDX_DATA:      s_axi_rdata[7:0] <= data_q;
                IDX_CONTROL:   s_axi_rdata[5:0] <= {mode_q, irqen_q, arm_q, busy_q, 1'b0};
                IDX_STATUS:    s_axi_rdata[ST_SELF] <= self_prog_active;
                default:       s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // check helpers
    // ---------------------------------------------------------------
    // busy-cycle tally for the duration check only; no reset, so a
    // cycle that runs through a reset is still measured whole
    logic             prog_end;
    logic [TMR_W-1:0] busy_len_q;
    assign prog_end = state_q == EEAC_PROG && tmr_q == '0;
    always_ff @(posedge aclk) begin
        if (start_prog) begin
            busy_len_q <= '0;
        end else if (busy_q) begin
            busy_len_q <= busy_len_q + TMR_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_arm_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(arm_q) |-> ##[1:4] !arm_q) else $error("arm bit not cleared in time");
    a_no_start_unarmed: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctl && w_data_q[CTL_BUSY] && !arm_q && !busy_q) |=> !busy_q)
        else $error("busy set without arm");
    a_start_armed: assert property (@(posedge aclk) disable iff (!aresetn)
        start_prog |=> busy_q) else $error("armed write did not start");
    a_mode_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
        (busy_q && $past(busy_q)) |-> $stable(mode_q)) else $error("mode changed while busy");
    a_addr_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
        (busy_q && $past(busy_q)) |-> $stable(addr_q)) else $error("address changed while busy");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == EEAC_IDLE && irqen_q && cpu_global_irq_en) |-> ready_irq)
        else $error("irq level wrong");
    a_wstall_two: assert property (@(posedge aclk) disable iff (!aresetn)
        start_prog |=> cpu_stall [*2] ##1 !cpu_stall) else $error("write stall not two");
    a_rstall_four: assert property (@(posedge aclk) disable iff (!aresetn)
        (start_read && !start_prog) |=> cpu_stall [*4] ##1 (!cpu_stall || start_read))
        else $error("read stall not four");
    a_read_data: assert property (@(posedge aclk) disable iff (!aresetn)
        start_read |=> data_q == mem_q[$past(addr_q)]) else $error("read data wrong");
    a_flash_block: assert property (@(posedge aclk) disable iff (!aresetn)
        (self_prog_active && !busy_q) |=> !busy_q) else $error("started during self-program");
    a_busy_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
        (state_q == EEAC_PROG && tmr_q == '0) |=> !busy_q) else $error("busy not cleared");
    a_arm_spent: assert property (@(posedge aclk) disable iff (!aresetn)
        start_prog |=> !arm_q) else $error("arm bit survived a start");
    a_arm_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctl && w_data_q[CTL_ARM] && w_data_q[CTL_BUSY] && !arm_q) |=> !arm_q)
        else $error("arm taken together with busy");
    a_rsvd_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctl && w_data_q[CTL_BUSY] && mode_next == MODE_RSVD && !busy_q) |=> !busy_q)
        else $error("reserved mode started a cycle");
    a_irq_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        (!cpu_global_irq_en || !irqen_q) |-> !ready_irq) else $error("irq not gated");
    a_read_refused: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctl && w_data_q[CTL_READ] && busy_q) |=> $stable(data_q))
        else $error("read performed while busy");
    a_addr_lo_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_addr_lo && !busy_q) |=> addr_q[7:0] == $past(w_data_q[7:0]))
        else $error("address low not loaded");
    a_addr_hi_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_addr_hi && !busy_q) |=> addr_q[ADDR_W-1:8] == $past(w_data_q[ADDR_W-9:0]))
        else $error("address high not loaded");
    a_mode_cleared: assert property (@(posedge aclk)
        (!aresetn && !busy_q) |=> mode_q == MODE_RESET) else $error("mode not cleared");
    a_mode_kept: assert property (@(posedge aclk)
        (!aresetn && busy_q) |=> $stable(mode_q)) else $error("mode lost over reset");
    a_addr_hi_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == IDX_ADDR_HIGH)
        |=> s_axi_rdata[31:4] == '0) else $error("address high upper bits not zero");
    a_ctl_rsv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == IDX_CONTROL)
        |=> s_axi_rdata[31:6] == '0) else $error("control upper bits not zero");
    a_cell_written: assert property (@(posedge aclk) disable iff (!aresetn)
        (prog_end && mode_q == MODE_ERASE_WRITE) |=> mem_q[$past(addr_q)] == $past(data_q))
        else $error("cell not programmed with data byte");
    a_cell_erased: assert property (@(posedge aclk) disable iff (!aresetn)
        (prog_end && mode_q == MODE_ERASE) |=> mem_q[$past(addr_q)] == ERASED_BYTE)
        else $error("cell not erased");
    a_cell_anded: assert property (@(posedge aclk) disable iff (!aresetn)
        (prog_end && mode_q == MODE_WRITE)
        |=> mem_q[$past(addr_q)] == ($past(mem_q[addr_q]) & $past(data_q)))
        else $error("write-only cell wrong");
    a_prog_time: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(busy_q) |-> busy_len_q == ((mode_q == MODE_ERASE_WRITE)
        ? TMR_W'(CYC_ATOMIC_P) : TMR_W'(CYC_SINGLE_P))) else $error("programming time wrong");
    c_prog: cover property (@(posedge aclk) start_prog);
    c_reset_busy: cover property (@(posedge aclk) !aresetn && busy_q);
    c_read: cover property (@(posedge aclk) start_read);
    c_done: cover property (@(posedge aclk) $fell(busy_q));
    c_timeout: cover property (@(posedge aclk) $fell(arm_q) && !busy_q);
endmodule
`default_nettype wire

// ==== hdl/eeac_pkg.sv ====
// eeac_pkg: register map, field layout and timing constants of the eeprom access controller
package eeac_pkg;
    // ---------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_ADDR_LOW  = 8'h21;
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h22;
    localparam logic [7:0] IDX_DATA      = 8'h23;
    localparam logic [7:0] IDX_CONTROL   = 8'h24;
    localparam logic [7:0] IDX_STATUS    = 8'h25;
    localparam int         ADDR_W        = 12;
    localparam int         DEPTH         = 4096;
    localparam logic [3:0] ADDR_HI_MASK  = 4'hF;
    // ---------------------------------------------------------------
    // control field positions
    // ---------------------------------------------------------------
    localparam int CTL_READ   = 0;
    localparam int CTL_BUSY   = 1;
    localparam int CTL_ARM    = 2;
    localparam int CTL_IRQEN  = 3;
    localparam int CTL_MODE_L = 4;
    localparam int CTL_MODE_H = 5;
    localparam int ST_SELF    = 0;
    localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
    localparam logic [1:0] MODE_ERASE       = 2'h1;
    localparam logic [1:0] MODE_WRITE       = 2'h2;
    localparam logic [1:0] MODE_RESET       = 2'h0;
    localparam logic [1:0] MODE_RSVD        = 2'h3;
    localparam logic [7:0] ERASED_BYTE      = 8'hFF;
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ       = 40000000;
    localparam int ARM_CYCLES   = 4;
    localparam int WSTALL_CYC   = 2;
    localparam int RSTALL_CYC   = 4;
    localparam int T_ATOMIC_US  = 3400;
    localparam int T_SINGLE_US  = 1800;
    localparam int CYC_ATOMIC   = T_ATOMIC_US * (CLK_HZ / 1000000);
    localparam int CYC_SINGLE   = T_SINGLE_US * (CLK_HZ / 1000000);
    localparam int TMR_W        = 18;
    typedef enum logic [1:0] {EEAC_IDLE, EEAC_PROG} eeac_state_type;
endpackage

// ==== testbench/eeac_tb.sv ====
// testbench: self-checking bench for the eeprom access controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import eeac_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    localparam int CA = 40;
    localparam int CS = 20;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic        cpu_global_irq_en = 1'b1, self_prog_active = 1'b0, cpu_stall, ready_irq;
    int          errors = 0, tests_run = 0, cyc = 0, stalls = 0, lows = 0;

    eeac_top #(.CYC_ATOMIC_P(CA), .CYC_SINGLE_P(CS)) i_eeac_top (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_global_irq_en,
        .self_prog_active, .cpu_stall, .ready_irq);

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    // stall and busy-time tallies; also cuts a hang short
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cpu_stall === 1'b1) stalls <= stalls + 1;
        if (ready_irq === 1'b0) lows <= lows + 1;
        if (cyc > 20000) begin
            errors++;
            results();
        end
    end

    // ---------------------------------------------------------------
    // bus and compare tasks
    // ---------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cnt(input string n, input int e, input int g);
        tests_run++;
        if (g != e) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", n, e, g);
        end
    endtask

    // called right after an edge so an arm-then-start pair fits the window
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        s_axi_awaddr <= {22'h0, i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                last_resp = s_axi_bresp;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] i, output logic [7:0] v);
        v = 8'hXX;
        s_axi_araddr <= {22'h0, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                v = s_axi_rdata[7:0];
                last_resp = s_axi_rresp;
                break;
            end
        end
    endtask

    // nothing may come between arm and start, or the window closes
    task automatic start(input logic [1:0] m);
        wr(IDX_CONTROL, {2'b00, m, 4'hC});
        wr(IDX_CONTROL, {2'b00, m, 4'hE});
    endtask

    task automatic wait_idle();
        logic [7:0] v;
        v = 8'h02;
        for (int n = 0; n < 60 && v[1] !== 1'b0; n++) rd(IDX_CONTROL, v);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] v;
        rd(IDX_CONTROL, v);
        chk("control after reset", 8'h00, v & 8'hFD);
        wr(IDX_ADDR_HIGH, 8'hFF);
        rd(IDX_ADDR_HIGH, v);
        chk("address high", 8'h0F, v);
        wr(IDX_ADDR_LOW, 8'h5A);
        rd(IDX_ADDR_LOW, v);
        chk("address low", 8'h5A, v);
        wr(IDX_CONTROL, 8'hC8);
        rd(IDX_CONTROL, v);
        chk("control upper bits", 8'h08, v & 8'hFD);
        wr(8'h30, 8'h11);
        chk("unmapped write resp", {6'h0, RESP_SLVERR}, {6'h0, last_resp});
        rd(8'h30, v);
        chk("unmapped read resp", {6'h0, RESP_SLVERR}, {6'h0, last_resp});
        cpu_global_irq_en <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("irq with global off", 8'h00, {7'h0, ready_irq});
        cpu_global_irq_en <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("irq level when idle", 8'h01, {7'h0, ready_irq});
        wr(IDX_CONTROL, 8'h00);
        chk("irq disabled", 8'h00, {7'h0, ready_irq});
        wr(IDX_CONTROL, 8'h08);
    endtask

    task automatic t_noarm();
        logic [7:0] v;
        wr(IDX_CONTROL, 8'h0A);
        rd(IDX_CONTROL, v);
        chk("busy without arm", 8'h00, {7'h0, v[1]});
        wr(IDX_CONTROL, 8'h0E);
        rd(IDX_CONTROL, v);
        chk("arm and busy at once", 8'h00, {7'h0, v[1]});
        wr(IDX_CONTROL, 8'h0C);
        repeat (6) @(posedge aclk);
        rd(IDX_CONTROL, v);
        chk("arm self clears", 8'h00, {7'h0, v[2]});
        wr(IDX_CONTROL, 8'h0A);
        rd(IDX_CONTROL, v);
        chk("busy after arm expired", 8'h00, {7'h0, v[1]});
        self_prog_active <= 1'b1;
        rd(IDX_STATUS, v);
        chk("status self prog", 8'h01, {7'h0, v[0]});
        start(MODE_ERASE_WRITE);
        rd(IDX_CONTROL, v);
        chk("start during self prog", 8'h00, {7'h0, v[1]});
        self_prog_active <= 1'b0;
        start(2'b11);
        rd(IDX_CONTROL, v);
        chk("reserved mode start", 8'h00, {7'h0, v[1]});
    endtask

    task automatic prog(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d,
                        input logic [7:0] e);
        logic [7:0] v;
        int         s0, l0;
        wr(IDX_DATA, d);
        wr(IDX_ADDR_HIGH, {4'h0, a[11:8]});
        wr(IDX_ADDR_LOW, a[7:0]);
        s0 = stalls;
        l0 = lows;
        start(m);
        rd(IDX_CONTROL, v);
        chk("busy set", 8'h01, {7'h0, v[1]});
        chk_cnt("start stall", WSTALL_CYC, stalls - s0);
        if (m == MODE_ERASE_WRITE) begin
            wr(IDX_CONTROL, 8'h1A);
            wr(IDX_ADDR_LOW, ~a[7:0]);
            s0 = stalls;
            wr(IDX_CONTROL, 8'h0B);
            rd(IDX_CONTROL, v);
            chk("mode held while busy", {6'h0, m}, {6'h0, v[5:4]});
            chk_cnt("no read while busy", 0, stalls - s0);
            rd(IDX_ADDR_LOW, v);
            chk("address held while busy", a[7:0], v);
        end
        wait_idle();
        chk_cnt("busy length", (m == MODE_ERASE_WRITE) ? CA : CS, lows - l0);
        s0 = stalls;
        wr(IDX_CONTROL, {2'b00, m, 4'h9});
        rd(IDX_DATA, v);
        chk("cell after program", e, v);
        // the strobe's stall outlasts the read above by one cycle
        repeat (4) @(posedge aclk);
        chk_cnt("read stall", RSTALL_CYC, stalls - s0);
    endtask

    task automatic t_reset();
        logic [7:0] v;
        start(MODE_ERASE);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_CONTROL, v);
        chk("mode kept over reset", 8'h12, v & 8'h3E);
        wait_idle();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_CONTROL, v);
        chk("mode cleared by reset", 8'h00, v & 8'h3E);
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_noarm();
        prog(MODE_ERASE_WRITE, 12'h123, 8'hA5, 8'hA5);
        prog(MODE_ERASE, 12'h123, 8'h00, ERASED_BYTE);
        prog(MODE_WRITE, 12'h123, 8'h3C, 8'h3C);
        prog(MODE_WRITE, 12'h123, 8'hF0, 8'h30);
        prog(MODE_ERASE_WRITE, 12'hFFF, 8'h81, 8'h81);
        t_reset();
        results();
    end
endmodule
`default_nettype wire
